// ==== tb/mcr_cfg_status_regs_sva.sv ====
`timescale 1ns/1ps
module mcr_cfg_status_regs_sva
    import mcr_pkg::*;
(
    input wire logic                       core_clk,                   // Clock
    input wire logic                       sys_rst,                    // Reset
    input wire logic                       clk_en,                     // Clock enable
    input wire logic [mcr_pkg::ADDR_W-1:0] reg_addr,                   // Address
    input wire logic [mcr_pkg::DATA_W-1:0] reg_wdata,                  // Write data
    input wire logic                       reg_wr,                     // Write strobe
    input wire logic                       reg_rd,                     // Read strobe
    input wire logic [mcr_pkg::DATA_W-1:0] reg_rdata,                  // Read data
    input wire logic [mcr_pkg::NQ-1:0]     queue_underrun_event,       // Underruns
    input wire logic [mcr_pkg::NQ-1:0]     queue_overflow_event,       // Overruns
    input wire logic                       incoherent_word_event,      // Error event
    input wire logic                       memory_clock_out_pos,       // Memory clock
    input wire logic                       memory_clock_out_neg,       // Memory clock inv
    input wire logic                       burst_length_select,        // Burst
    input wire logic [1:0]                 input_clock_source_select,  // Source
    input wire logic                       output_clock_source_select, // Out source
    input wire logic [2:0]                 pll_numerator,              // Numerator
    input wire logic [2:0]                 pll_denominator,            // Denominator
    input wire logic                       memctl_fifo_summary_irq,    // Queue summary
    input wire logic                       memctl_other_summary_irq    // Other summary
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic wr_mode = reg_wr && clk_en && reg_addr == OFS_MODE;
    wire logic wr_pll  = reg_wr && clk_en && reg_addr == OFS_PLL;
    wire logic rd_go   = reg_rd && clk_en;
    wire logic any_q   = |{queue_underrun_event, queue_overflow_event};
    wire logic rd_rsv  = rd_go && (reg_addr == OFS_RSV_CFG_A || reg_addr == OFS_RSV_CFG_B
                                   || reg_addr == OFS_RSV_STS);
    AST_BURST: assert property (wr_mode |=> burst_length_select == $past(reg_wdata[0]))
        else $error("burst select does not follow mode write");
    AST_ICK: assert property (wr_mode |=> input_clock_source_select
        == {$past(reg_wdata[2]), $past(reg_wdata[3])}) else $error("clock source code wrong");
    AST_OCK: assert property (wr_mode |=> output_clock_source_select == $past(reg_wdata[7]))
        else $error("output clock select wrong");
    AST_PLL: assert property (wr_pll |=> pll_numerator == {$past(reg_wdata[1]),
        $past(reg_wdata[2]), $past(reg_wdata[3])} && pll_denominator == {$past(reg_wdata[5]),
        $past(reg_wdata[6]), $past(reg_wdata[7])}) else $error("ratio fields wrong");
    AST_RSV: assert property (rd_rsv |=> reg_rdata == 8'h00)
        else $error("reserved location read nonzero");
    AST_ERR_RSV: assert property (rd_go && reg_addr == OFS_ERR_STS |=> reg_rdata[6:0] == 7'h00)
        else $error("error status reserved bits nonzero");
    AST_MODE_RD: assert property (rd_go && reg_addr == OFS_MODE |=> reg_rdata ==
        {$past(output_clock_source_select), 3'h0, $past(input_clock_source_select[0]),
        $past(input_clock_source_select[1]), 1'b0, $past(burst_length_select)})
        else $error("mode readback wrong");
    AST_IDLE: assert property (!reg_rd && clk_en |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_QSUM: assert property ($rose(memctl_fifo_summary_irq) |-> $past(any_q))
        else $error("queue summary without event");
    AST_OSUM: assert property ($rose(memctl_other_summary_irq) |-> $past(incoherent_word_event))
        else $error("other summary without event");
    AST_MCK: assert property (memory_clock_out_neg != memory_clock_out_pos)
        else $error("memory clock pair not complementary");
endmodule : mcr_cfg_status_regs_sva

bind mcr_cfg_status_regs mcr_cfg_status_regs_sva u_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .queue_underrun_event(queue_underrun_event), .queue_overflow_event(queue_overflow_event),
    .incoherent_word_event(incoherent_word_event), .memory_clock_out_pos(memory_clock_out_pos),
    .memory_clock_out_neg(memory_clock_out_neg), .burst_length_select(burst_length_select),
    .input_clock_source_select(input_clock_source_select),
    .output_clock_source_select(output_clock_source_select), .pll_numerator(pll_numerator),
    .pll_denominator(pll_denominator), .memctl_fifo_summary_irq(memctl_fifo_summary_irq),
    .memctl_other_summary_irq(memctl_other_summary_irq));

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import mcr_pkg::*;
    logic              core_clk = 1'b0;
    logic              sys_rst  = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0]        reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [NQ-1:0]     q_un = '0;
    logic [NQ-1:0]     q_ov = '0;
    logic              inc_ev = 1'b0;
    logic              ce = 1'b1;
    logic [5:0]        ref_cnt = '0;
    logic [7:0]        rdat, rv, n_sel, n_mem;
    logic              selc, mckp, mckn, burst, ock, sum_q, sum_o, irq;
    logic [1:0]        ick;
    logic [2:0]        pn, pd;
    int                n_errors = 0;
    int                comparisons = 0;
    always #2.5 core_clk = ~core_clk;
    // Slow references keep every source below half the core rate
    always @(posedge core_clk) ref_cnt <= ref_cnt + 6'h01;
    mcr_cfg_status_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdat), .queue_underrun_event(q_un), .queue_overflow_event(q_ov),
        .incoherent_word_event(inc_ev), .dedicated_memory_ref_clock(ref_cnt[2]),
        .first_link_ref_clock(ref_cnt[3]), .second_link_ref_clock(ref_cnt[4]),
        .fabric_supplied_ref_clock(ref_cnt[5]), .double_rate_synth_clock(ref_cnt[1]),
        .selected_input_clock(selc), .memory_clock_out_pos(mckp), .memory_clock_out_neg(mckn),
        .burst_length_select(burst), .input_clock_source_select(ick),
        .output_clock_source_select(ock), .pll_numerator(pn), .pll_denominator(pd),
        .memctl_fifo_summary_irq(sum_q), .memctl_other_summary_irq(sum_o), .irq(irq));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [19:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdat, exp);
    endtask : rchk
    task automatic ev(input logic [7:0] q, input logic e);
        @(posedge core_clk);
        q_un   <= q[3:0];
        q_ov   <= q[7:4];
        inc_ev <= e;
        @(posedge core_clk);
        #1;
    endtask : ev
    // Counts rises over 256 cycles, a whole number of periods of every reference
    task automatic clk_count(output logic [7:0] ns, output logic [7:0] nm);
        logic ps;
        logic pm;
        repeat (80) @(posedge core_clk);
        #1;
        ns = 8'h00;
        nm = 8'h00;
        ps = selc;
        pm = mckp;
        repeat (256) begin
            @(posedge core_clk);
            #1;
            if (selc && !ps) ns = ns + 8'h01;
            if (mckp && !pm) nm = nm + 8'h01;
            ps = selc;
            pm = mckp;
        end
    endtask : clk_count
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    localparam logic [19:0] ZERO_AT [9] = '{OFS_QUEUE_EN, OFS_ERR_EN, OFS_MODE, OFS_PLL,
        OFS_QUEUE_STS, OFS_ERR_STS, OFS_SUMMARY, OFS_IRQ_STS, OFS_IRQ_MASK};
    localparam logic [19:0] RSV_AT [5] = '{OFS_RSV_CFG_A, OFS_RSV_CFG_B, OFS_RSV_STS,
        20'h30B0F, OFS_QUEUE_STS};
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (ZERO_AT[k]) rchk(ZERO_AT[k], 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("test reset values done");
        for (int c = 0; c < 4; c++) begin
            rv = {1'b1, 3'h0, c[0], c[1], 1'b0, c[0]};
            wr(OFS_MODE, rv);
            chk({6'h0, ick}, c[7:0]);
            chk({7'h0, burst}, {7'h0, c[0]});
            chk({7'h0, ock}, 8'h01);
            rchk(OFS_MODE, rv);
            clk_count(n_sel, n_mem);
            chk(n_sel, 8'h20 >> c);
            chk(n_mem, 8'h40);
        end
        wr(OFS_MODE, 8'hFF);
        rchk(OFS_MODE, 8'h8D);
        wr(OFS_MODE, 8'h00);
        chk({7'h0, ock}, 8'h00);
        clk_count(n_sel, n_mem);
        chk(n_sel, 8'h20);
        chk(n_mem, 8'h10);
        wr(OFS_MODE, 8'h0C);
        clk_count(n_sel, n_mem);
        chk(n_sel, 8'h04);
        chk(n_mem, 8'h02);
        wr(OFS_PLL, 8'hFF);
        rchk(OFS_PLL, 8'hEE);
        wr(OFS_PLL, 8'h4A);
        chk({2'h0, pn, pd}, 8'h2A);
        ce <= 1'b0;
        wr(OFS_PLL, 8'h00);
        ce <= 1'b1;
        rchk(OFS_PLL, 8'h4A);
        foreach (RSV_AT[k]) begin
            wr(RSV_AT[k], 8'hFF);
            rchk(RSV_AT[k], 8'h00);
        end
        $display("test config done");
        ev(8'hFF, 1'b1);
        rchk(OFS_QUEUE_STS, 8'h00);
        rchk(OFS_ERR_STS, 8'h00);
        chk({6'h0, sum_q, sum_o}, 8'h00);
        ev(8'h00, 1'b0);
        wr(OFS_QUEUE_EN, 8'hFF);
        rchk(OFS_QUEUE_EN, 8'hFF);
        wr(OFS_IRQ_MASK, 8'h03);
        for (int i = 0; i < 8; i++) begin
            ev(8'h01 << i, 1'b0);
            ev(8'h00, 1'b0);
            chk({7'h0, sum_q}, 8'h01);
            rchk(OFS_QUEUE_STS, 8'h01 << i);
            rchk(OFS_QUEUE_STS, 8'h00);
        end
        chk({7'h0, irq}, 8'h01);
        rchk(OFS_SUMMARY, 8'h04);
        rchk(OFS_SUMMARY, 8'h00);
        rchk(OFS_IRQ_STS, 8'h01);
        wr(OFS_IRQ_STS, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(OFS_IRQ_MASK, 8'h00);
        ev(8'h10, 1'b0);
        rchk(OFS_SUMMARY, 8'h04);
        rchk(OFS_SUMMARY, 8'h00);
        chk({7'h0, irq}, 8'h00);
        ev(8'h00, 1'b0);
        wr(OFS_IRQ_MASK, 8'h03);
        chk({7'h0, irq}, 8'h01);
        wr(OFS_IRQ_STS, 8'h03);
        chk({7'h0, irq}, 8'h00);
        $display("test queue flags done");
        wr(OFS_ERR_EN, 8'hFF);
        rchk(OFS_ERR_EN, 8'h80);
        ev(8'h00, 1'b1);
        ev(8'h00, 1'b0);
        chk({7'h0, sum_o}, 8'h01);
        rchk(OFS_ERR_STS, 8'h80);
        rchk(OFS_ERR_STS, 8'h00);
        rchk(OFS_SUMMARY, 8'h02);
        rchk(OFS_IRQ_STS, 8'h02);
        chk({7'h0, irq}, 8'h01);
        $display("test incoherent error done");
        report_and_stop();
    end
endmodule : tb_top

// ==== verilog/mcr_cfg_status_regs.sv ====
`timescale 1ns/1ps
// Behaviour
// R01 - Error enable bit 7 gates incoherent-word flag and its non-queue summary interrupt.
// R02 - Mode bit 0: zero gives two-word bursts, one gives four-word bursts.
// R03 - Bits 2..3 pick dedicated, first link, second link or fabric reference.
// R04 - Mode bit 7: memory clock from selected clock halved, or synthesiser.
// R05 - Synthesiser rate is selected clock times numerator over denominator field.
// R06 - Queue status bits 0..3 report underrun: read data, read instr, write data, write instr.
// R07 - Queue status bits 4..7 report overrun in the same queue order.
// R08 - Each queue flag rises only while its enable bit is set.
// R09 - Error status bit 7 reports incoherent words, gated by its enable.
// R10 - Queue enable register holds eight enables gating flags and queue summary.
// R11 - Enabled queue event sets queue summary bit; read clears; reasserts on new onset.
// R12 - Enabled incoherent error sets other summary bit, same clear-on-read behaviour.
// R13 - Reserved bits and locations read zero and ignore writes.
module mcr_cfg_status_regs (
    input  wire logic                       core_clk,                    // 200 MHz clock
    input  wire logic                       sys_rst,                     // Sync reset, high
    input  wire logic                       clk_en,                      // Clock enable
    input  wire logic [mcr_pkg::ADDR_W-1:0] reg_addr,                    // Register address
    input  wire logic [mcr_pkg::DATA_W-1:0] reg_wdata,                   // Write data
    input  wire logic                       reg_wr,                      // Write strobe
    input  wire logic                       reg_rd,                      // Read strobe
    output logic      [mcr_pkg::DATA_W-1:0] reg_rdata,                   // Read data, next cycle
    input  wire logic [mcr_pkg::NQ-1:0]     queue_underrun_event,        // Underrun levels
    input  wire logic [mcr_pkg::NQ-1:0]     queue_overflow_event,        // Overrun levels
    input  wire logic                       incoherent_word_event,       // Incoherent words
    input  wire logic                       dedicated_memory_ref_clock,  // Pin reference
    input  wire logic                       first_link_ref_clock,        // Pin reference
    input  wire logic                       second_link_ref_clock,       // Pin reference
    input  wire logic                       fabric_supplied_ref_clock,   // Fabric reference
    input  wire logic                       double_rate_synth_clock,     // Synthesiser output
    output logic                            selected_input_clock,        // Muxed reference
    output logic                            memory_clock_out_pos,        // Memory clock
    output logic                            memory_clock_out_neg,        // Memory clock, inv
    output logic                            burst_length_select,         // 0 two, 1 four
    output logic      [1:0]                 input_clock_source_select,   // Source code
    output logic                            output_clock_source_select,  // 0 halved, 1 synth
    output logic      [2:0]                 pll_numerator,               // Synth numerator
    output logic      [2:0]                 pll_denominator,             // Synth denominator
    output logic                            memctl_fifo_summary_irq,     // Queue summary bit
    output logic                            memctl_other_summary_irq,    // Other summary bit
    output logic                            irq                          // Level interrupt
);
    import mcr_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Register storage
    logic [DATA_W-1:0] queue_en_reg;
    logic [DATA_W-1:0] err_en_reg;
    logic [DATA_W-1:0] mode_reg;
    logic [DATA_W-1:0] pll_reg;
    logic [DATA_W-1:0] irq_mask_reg;
    logic [DATA_W-1:0] irq_sts_reg;
    logic [DATA_W-1:0] irq_sts_next;
    logic [DATA_W-1:0] queue_sts_reg;
    logic [DATA_W-1:0] queue_sts_next;
    logic              id_err_reg;
    logic              id_err_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // Address decode
    wire wr_queue_en = reg_wr & hit(reg_addr, OFS_QUEUE_EN);
    wire wr_err_en   = reg_wr & hit(reg_addr, OFS_ERR_EN);
    wire wr_mode     = reg_wr & hit(reg_addr, OFS_MODE);
    wire wr_pll      = reg_wr & hit(reg_addr, OFS_PLL);
    wire wr_irq_sts  = reg_wr & hit(reg_addr, OFS_IRQ_STS);
    wire wr_irq_mask = reg_wr & hit(reg_addr, OFS_IRQ_MASK);
    wire rd_queue    = reg_rd & hit(reg_addr, OFS_QUEUE_STS);
    wire rd_err      = reg_rd & hit(reg_addr, OFS_ERR_STS);
    wire rd_summary  = reg_rd & hit(reg_addr, OFS_SUMMARY);

    // Event gating
    wire [DATA_W-1:0] queue_event = {queue_overflow_event, queue_underrun_event};
    // R10 per-queue enables
    wire [DATA_W-1:0] queue_gated = queue_event & queue_en_reg;
    // R01 incoherent-word enable
    wire              id_gated    = incoherent_word_event & err_en_reg[BIT_ID_ERR];

    // R08 flags rise only while enabled; dropping an enable clears the flag
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_queue_flag
            assign queue_sts_next[gi] = queue_en_reg[gi] &
                                        (queue_event[gi] | (queue_sts_reg[gi] & ~rd_queue));
        end
    endgenerate

    // R09 incoherent-word flag, gated by its enable
    assign id_err_next = err_en_reg[BIT_ID_ERR] &
                         (incoherent_word_event | (id_err_reg & ~rd_err));

    // Summary bits
    logic fifo_sum;
    logic fifo_rise;
    logic other_sum;
    logic other_rise;

    // R11 queue summary, onset-set and clear-on-read
    mcr_summary_bit u_fifo_sum (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .cond     (|queue_gated),
        .rd_clear (rd_summary),
        .flag     (fifo_sum),
        .rise     (fifo_rise)
    );

    // R12 non-queue summary from the incoherent-word error
    mcr_summary_bit u_other_sum (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .cond     (id_gated),
        .rd_clear (rd_summary),
        .flag     (other_sum),
        .rise     (other_rise)
    );

    // Sticky interrupt status; a new onset beats a same-cycle write-one clear
    wire [DATA_W-1:0] irq_set = {6'h00, other_rise, fifo_rise};
    wire [DATA_W-1:0] irq_clr = wr_irq_sts ? (reg_wdata & IRQ_WMASK) : 8'h00;
    assign irq_sts_next = irq_set | (irq_sts_reg & ~irq_clr);

    // Read multiplexer
    wire [DATA_W-1:0] summary_val = (8'h01 << BIT_SUM_QUEUE) & {DATA_W{fifo_sum}}
                                  | (8'h01 << BIT_SUM_OTHER) & {DATA_W{other_sum}};
    wire [DATA_W-1:0] err_sts_val = {id_err_reg, 7'h00};
    // R13 reserved locations and unmapped addresses read zero
    assign rdata_next = !reg_rd                         ? 8'h00 :
                        hit(reg_addr, OFS_QUEUE_EN)     ? queue_en_reg :
                        hit(reg_addr, OFS_ERR_EN)       ? err_en_reg :
                        hit(reg_addr, OFS_MODE)         ? mode_reg :
                        hit(reg_addr, OFS_PLL)          ? pll_reg :
                        hit(reg_addr, OFS_QUEUE_STS)    ? queue_sts_reg :
                        hit(reg_addr, OFS_ERR_STS)      ? err_sts_val :
                        hit(reg_addr, OFS_SUMMARY)      ? summary_val :
                        hit(reg_addr, OFS_IRQ_STS)      ? irq_sts_reg :
                        hit(reg_addr, OFS_IRQ_MASK)     ? irq_mask_reg :
                                                          8'h00;

    // R13 only documented bits store writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            queue_en_reg <= RST_QUEUE_EN;
            err_en_reg   <= RST_ERR_EN;
            mode_reg     <= RST_MODE;
            pll_reg      <= RST_PLL;
            irq_mask_reg <= RST_IRQ_MASK;
        end else if (clk_en) begin
            if (wr_queue_en) queue_en_reg <= reg_wdata;
            if (wr_err_en)   err_en_reg   <= reg_wdata & ERR_EN_WMASK;
            if (wr_mode)     mode_reg     <= reg_wdata & MODE_WMASK;
            if (wr_pll)      pll_reg      <= reg_wdata & PLL_WMASK;
            if (wr_irq_mask) irq_mask_reg <= reg_wdata & IRQ_WMASK;
        end
    end

    // R06 R07 queue status bits in documented order
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            queue_sts_reg <= 8'h00;
            id_err_reg    <= 1'b0;
            irq_sts_reg   <= 8'h00;
            rdata_reg     <= 8'h00;
        end else if (clk_en) begin
            queue_sts_reg <= queue_sts_next;
            id_err_reg    <= id_err_next;
            irq_sts_reg   <= irq_sts_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign reg_rdata                = rdata_reg;
    assign memctl_fifo_summary_irq  = fifo_sum;
    assign memctl_other_summary_irq = other_sum;
    assign irq                      = |(irq_sts_reg & irq_mask_reg);

    // R02 burst length
    assign burst_length_select        = mode_reg[BIT_BURST];
    // R03 source code, bit 2 is the upper code bit
    assign input_clock_source_select  = {mode_reg[BIT_ICK_HI], mode_reg[BIT_ICK_LO]};
    assign output_clock_source_select = mode_reg[BIT_OCK];
    // R05 ratio fields drive the synthesiser, bit 1 and bit 5 upper
    assign pll_numerator   = {pll_reg[BIT_PLL_N_HI], pll_reg[BIT_PLL_N_MID],
                              pll_reg[BIT_PLL_N_LO]};
    assign pll_denominator = {pll_reg[BIT_PLL_M_HI], pll_reg[BIT_PLL_M_MID],
                              pll_reg[BIT_PLL_M_LO]};

    // Reference inputs are sampled, so they must run well below core_clk / 2
    logic [4:0] ck_sync1_reg;
    logic [4:0] ck_sync2_reg;
    wire  [4:0] ck_pins = {double_rate_synth_clock, fabric_supplied_ref_clock,
                           second_link_ref_clock, first_link_ref_clock,
                           dedicated_memory_ref_clock};

    generate
        for (gi = 0; gi < 5; gi++) begin : g_ck_sync
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    ck_sync1_reg[gi] <= 1'b0;
                    ck_sync2_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    ck_sync1_reg[gi] <= ck_pins[gi];
                    ck_sync2_reg[gi] <= ck_sync1_reg[gi];
                end
            end
        end
    endgenerate

    // R03 source multiplexer
    wire sel_ck = (input_clock_source_select == CK_SRC_DEDICATED) ? ck_sync2_reg[0] :
                  (input_clock_source_select == CK_SRC_FIRST)     ? ck_sync2_reg[1] :
                  (input_clock_source_select == CK_SRC_SECOND)    ? ck_sync2_reg[2] :
                                                                    ck_sync2_reg[3];

    logic sel_ck_reg;
    logic half_ck_reg;
    logic mem_ck_reg;
    logic mem_ck_n_reg;
    wire  sel_ck_rise = sel_ck & ~sel_ck_reg;
    // R04 halved selected clock or synthesiser output
    wire  mem_ck_next = (output_clock_source_select == OCK_SYNTH) ? ck_sync2_reg[4]
                                                                  : half_ck_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_ck_reg   <= 1'b0;
            half_ck_reg  <= 1'b0;
            mem_ck_reg   <= 1'b0;
            mem_ck_n_reg <= 1'b1;
        end else if (clk_en) begin
            sel_ck_reg   <= sel_ck;
            // R04 divide by two
            if (sel_ck_rise) half_ck_reg <= ~half_ck_reg;
            mem_ck_reg   <= mem_ck_next;
            mem_ck_n_reg <= ~mem_ck_next;
        end
    end

    assign selected_input_clock = sel_ck_reg;
    assign memory_clock_out_pos = mem_ck_reg;
    assign memory_clock_out_neg = mem_ck_n_reg;

endmodule : mcr_cfg_status_regs

// ==== verilog/mcr_pkg.sv ====
package mcr_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int NQ     = 4;

    // Register offsets
    localparam logic [19:0] OFS_QUEUE_EN    = 20'h30B01;
    localparam logic [19:0] OFS_ERR_EN      = 20'h30B02;
    localparam logic [19:0] OFS_MODE        = 20'h30B03;
    localparam logic [19:0] OFS_PLL         = 20'h30B04;
    localparam logic [19:0] OFS_RSV_CFG_A   = 20'h30B05;
    localparam logic [19:0] OFS_RSV_CFG_B   = 20'h30B06;
    localparam logic [19:0] OFS_QUEUE_STS   = 20'h30B08;
    localparam logic [19:0] OFS_ERR_STS     = 20'h30B09;
    localparam logic [19:0] OFS_RSV_STS     = 20'h30B0A;
    localparam logic [19:0] OFS_SUMMARY     = 20'h30B29;
    localparam logic [19:0] OFS_IRQ_STS     = 20'h30B30;
    localparam logic [19:0] OFS_IRQ_MASK    = 20'h30B31;

    // Field positions
    localparam int BIT_ID_ERR    = 7;
    localparam int BIT_BURST     = 0;
    localparam int BIT_ICK_HI    = 2;
    localparam int BIT_ICK_LO    = 3;
    localparam int BIT_OCK       = 7;
    localparam int BIT_PLL_N_HI  = 1;
    localparam int BIT_PLL_N_MID = 2;
    localparam int BIT_PLL_N_LO  = 3;
    localparam int BIT_PLL_M_HI  = 5;
    localparam int BIT_PLL_M_MID = 6;
    localparam int BIT_PLL_M_LO  = 7;
    localparam int BIT_UNDER_LO  = 0;
    localparam int BIT_OVER_LO   = 4;
    localparam int BIT_SUM_OTHER = 1;
    localparam int BIT_SUM_QUEUE = 2;
    localparam int BIT_IRQ_QUEUE = 0;
    localparam int BIT_IRQ_OTHER = 1;

    // Writable bit masks; all other bits are reserved
    localparam logic [7:0] ERR_EN_WMASK = 8'h80;
    localparam logic [7:0] MODE_WMASK   = 8'h8D;
    localparam logic [7:0] PLL_WMASK    = 8'hEE;
    localparam logic [7:0] IRQ_WMASK    = 8'h03;

    // Reset values
    localparam logic [7:0] RST_QUEUE_EN = 8'h00;
    localparam logic [7:0] RST_ERR_EN   = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_PLL      = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // Input clock source codes
    localparam logic [1:0] CK_SRC_DEDICATED = 2'h0;
    localparam logic [1:0] CK_SRC_FIRST     = 2'h1;
    localparam logic [1:0] CK_SRC_SECOND    = 2'h2;
    localparam logic [1:0] CK_SRC_FABRIC    = 2'h3;

    // Burst length and output clock source codes
    localparam logic BURST_TWO_WORD  = 1'b0;
    localparam logic BURST_FOUR_WORD = 1'b1;
    localparam logic OCK_DIVIDED     = 1'b0;
    localparam logic OCK_SYNTH       = 1'b1;

endpackage : mcr_pkg

// ==== verilog/mcr_summary_bit.sv ====
`timescale 1ns/1ps
module mcr_summary_bit (
    input  wire logic core_clk,   // System clock
    input  wire logic sys_rst,    // Synchronous reset, active high
    input  wire logic clk_en,     // Freezes state while low
    input  wire logic cond,       // Enabled underlying condition
    input  wire logic rd_clear,   // Summary register read strobe
    output logic      flag,       // Summary flag
    output logic      rise        // One-cycle pulse on condition onset
);
    import mcr_pkg::*;

    logic cond_d_reg;
    logic flag_reg;
    logic flag_next;

    // Only an onset sets the flag, so a persisting condition stays cleared after a read
    assign rise      = cond & ~cond_d_reg & clk_en;
    assign flag_next = rise | (flag_reg & ~rd_clear);
    assign flag      = flag_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cond_d_reg <= 1'b0;
            flag_reg   <= 1'b0;
        end else if (clk_en) begin
            cond_d_reg <= cond;
            flag_reg   <= flag_next;
        end
    end

endmodule : mcr_summary_bit
